// ==== src/usb_global_event_and_address.sv ====
// Global USB event flags, their interrupt enables and the device address.
// Assumes serial engine event inputs are synchronous one-cycle pulses or levels,
// and a CPU special function register port with single-cycle read and write strobes.
//
// Overview of operation
// - In suspend, bus activity sets wake flag bit 5; own resume never does.
// - End of bus reset sets flag bit 4 until software clears it.
// - Start-of-frame token sets flag bit 3 until software clears it.
// - Each flag reaches the interrupt only with its enable at same bit.
// - Reserved bits 7-6, 2, 1 read zero; software writes them zero.
// - Enable register resets to 10h, reset-end enable only.
// - Address register bit 7 switches address filtering on or off.
// - Device address field is zero after power-up and every bus reset.
`timescale 1ns/10ps
`default_nettype none
module usb_global_event_and_address
    import usb_event_pkg::*;
#(
    parameter int IDLE_CYCLES = SUSPEND_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Serial engine events
    input  wire logic       bus_reset_end,
    input  wire logic       sof_pid_seen,
    input  wire logic       line_j_idle,
    input  wire logic       line_active,
    input  wire logic       upstream_resume,
    // Received tokens
    input  wire logic       token_valid,
    input  wire logic [6:0] token_addr,
    output logic            token_accept,
    // Status and control out
    output logic            usb_irq,
    output logic            suspended,
    output logic            addr_filter_on,
    output logic      [6:0] device_address_field,
    output logic      [3:0] endpoint_select
);

    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] enables_reg;
    logic [7:0] enables_next;
    logic       filter_reg;
    logic [6:0] address_reg;
    logic [3:0] ep_select_reg;
    logic       suspended_reg;
    logic       suspended_next;
    logic       irq_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_mux;

    // Address decode
    logic wr_flags;
    logic wr_enables;
    logic wr_address;
    logic wr_ep_select;
    assign wr_flags     = sfr_wr && (sfr_addr == EVENT_FLAGS_ADDR);
    assign wr_enables   = sfr_wr && (sfr_addr == EVENT_ENABLES_ADDR);
    assign wr_address   = sfr_wr && (sfr_addr == DEVICE_ADDR_ADDR);
    assign wr_ep_select = sfr_wr && (sfr_addr == EP_SELECT_ADDR);

    // Suspend detection
    logic suspend_detect;
    idle_suspend_timer #(
        .IDLE_CYCLES (IDLE_CYCLES)
    ) u_idle_timer (
        .clk            (clk),
        .resetn         (resetn),
        .line_j_idle    (line_j_idle),
        .suspend_detect (suspend_detect)
    );

    // Wake only counts real bus signalling, never our own upstream resume
    logic wake_event;
    assign wake_event = suspended_reg && line_active && !upstream_resume;

    // Suspended state: entered on idle timeout, left on any bus activity
    assign suspended_next = suspend_detect ? 1'b1 :
                            (line_active ? 1'b0 : suspended_reg);

    // Set events gathered at their flag positions
    logic [7:0] set_vec;
    assign set_vec = {2'b00,
                      wake_event,
                      bus_reset_end,
                      sof_pid_seen,
                      2'b00,
                      suspend_detect};

    // Writing zero clears a flag; a set in the same cycle wins
    logic [7:0] clr_vec;
    assign clr_vec    = wr_flags ? (~sfr_wdata & EVENT_MASK) : 8'h00;
    assign flags_next = ((flags_reg & ~clr_vec) | set_vec) & EVENT_MASK;

    // Reserved enable bits are forced low whatever software writes
    assign enables_next = wr_enables ? (sfr_wdata & EVENT_MASK) : enables_reg;

    // Read data selection; unmapped addresses read zero
    assign rdata_mux = (sfr_addr == EVENT_FLAGS_ADDR)   ? flags_reg                    :
                       (sfr_addr == EVENT_ENABLES_ADDR) ? enables_reg                  :
                       (sfr_addr == DEVICE_ADDR_ADDR)   ? {filter_reg, address_reg}    :
                       (sfr_addr == EP_SELECT_ADDR)     ? {4'h0, ep_select_reg}        :
                                                          8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_reg     <= EVENT_FLAGS_RESET;
            enables_reg   <= EVENT_ENABLES_RESET;
            suspended_reg <= 1'b0;
            irq_reg       <= 1'b0;
        end else begin
            flags_reg     <= flags_next;
            enables_reg   <= enables_next;
            suspended_reg <= suspended_next;
            irq_reg       <= |(flags_next & enables_next);
        end
    end

    // Address register; a bus reset returns the address to default
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filter_reg  <= DEVICE_ADDR_RESET[FILTER_ON_BIT];
            address_reg <= DEVICE_ADDR_RESET[6:0];
        end else if (bus_reset_end) begin
            address_reg <= DEFAULT_ADDRESS;
            if (wr_address) begin
                filter_reg <= sfr_wdata[FILTER_ON_BIT];
            end
        end else if (wr_address) begin
            filter_reg  <= sfr_wdata[FILTER_ON_BIT];
            address_reg <= sfr_wdata[6:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ep_select_reg <= EP_SELECT_RESET;
        end else if (wr_ep_select) begin
            ep_select_reg <= sfr_wdata[3:0] & EP_SELECT_MASK;
        end
    end

    // Read data is held until the next read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 8'h00;
        end else if (sfr_rd) begin
            rdata_reg <= rdata_mux;
        end
    end

    token_address_filter u_token_filter (
        .clk          (clk),
        .resetn       (resetn),
        .filter_on    (filter_reg),
        .own_address  (address_reg),
        .token_valid  (token_valid),
        .token_addr   (token_addr),
        .token_accept (token_accept)
    );

    assign sfr_rdata            = rdata_reg;
    assign usb_irq              = irq_reg;
    assign suspended            = suspended_reg;
    assign addr_filter_on       = filter_reg;
    assign device_address_field = address_reg;
    assign endpoint_select      = ep_select_reg;

    // Checks

    property p_wake_set;
        @(posedge clk) disable iff (!resetn)
        suspended_reg && line_active && !upstream_resume |=> flags_reg[BUS_WAKE_BIT];
    endproperty
    a_wake_set: assert property (p_wake_set)
        else $error("bus wake flag not set on activity in suspend");

    property p_wake_quiet;
        @(posedge clk) disable iff (!resetn)
        !flags_reg[BUS_WAKE_BIT] && (upstream_resume || !suspended_reg)
            |=> !flags_reg[BUS_WAKE_BIT];
    endproperty
    a_wake_quiet: assert property (p_wake_quiet)
        else $error("bus wake flag set without bus wake-up");

    property p_reset_end;
        @(posedge clk) disable iff (!resetn)
        bus_reset_end |=> flags_reg[RESET_END_BIT] && (device_address_field == 7'h00);
    endproperty
    a_reset_end: assert property (p_reset_end)
        else $error("bus reset end did not set flag and clear address");

    property p_frame_start;
        @(posedge clk) disable iff (!resetn)
        sof_pid_seen ##1 !wr_flags |=> flags_reg[FRAME_START_BIT];
    endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("frame start flag lost before software cleared it");

    property p_suspend;
        @(posedge clk) disable iff (!resetn)
        suspend_detect |=> flags_reg[SUSPEND_BIT] && suspended;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend detect did not set suspend flag");

    property p_irq;
        @(posedge clk) disable iff (!resetn)
        (flags_reg & enables_reg) == 8'h00 |-> !usb_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt raised with no enabled flag");

    property p_irq_on;
        @(posedge clk) disable iff (!resetn)
        $rose(flags_reg[RESET_END_BIT]) && enables_reg[RESET_END_BIT] |-> usb_irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("enabled flag did not raise interrupt");

    property p_reserved;
        @(posedge clk) disable iff (!resetn)
        sfr_rd && (sfr_addr == EVENT_FLAGS_ADDR || sfr_addr == EVENT_ENABLES_ADDR)
            |=> (sfr_rdata & ~EVENT_MASK) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit read as one");

    property p_clear;
        @(posedge clk) disable iff (!resetn)
        wr_flags && !sfr_wdata[SUSPEND_BIT] && !suspend_detect |=> !flags_reg[SUSPEND_BIT];
    endproperty
    a_clear: assert property (p_clear)
        else $error("writing zero did not clear the flag");

    property p_irq_wake;
        @(posedge clk) disable iff (!resetn)
        $rose(flags_reg[BUS_WAKE_BIT]) && enables_reg[BUS_WAKE_BIT] |-> usb_irq;
    endproperty
    a_irq_wake: assert property (p_irq_wake)
        else $error("enabled wake flag did not raise interrupt");

    property p_irq_frame;
        @(posedge clk) disable iff (!resetn)
        $rose(flags_reg[FRAME_START_BIT]) && enables_reg[FRAME_START_BIT] |-> usb_irq;
    endproperty
    a_irq_frame: assert property (p_irq_frame)
        else $error("enabled frame start flag did not raise interrupt");

    property p_irq_suspend;
        @(posedge clk) disable iff (!resetn)
        $rose(flags_reg[SUSPEND_BIT]) && enables_reg[SUSPEND_BIT] |-> usb_irq;
    endproperty
    a_irq_suspend: assert property (p_irq_suspend)
        else $error("enabled suspend flag did not raise interrupt");

    // Flags may only fall through a software write of zero
    property p_hold_reset_end;
        @(posedge clk) disable iff (!resetn)
        flags_reg[RESET_END_BIT] && !(wr_flags && !sfr_wdata[RESET_END_BIT])
            |=> flags_reg[RESET_END_BIT];
    endproperty
    a_hold_reset_end: assert property (p_hold_reset_end)
        else $error("reset end flag dropped without a software clear");

    property p_hold_frame;
        @(posedge clk) disable iff (!resetn)
        flags_reg[FRAME_START_BIT] && !(wr_flags && !sfr_wdata[FRAME_START_BIT])
            |=> flags_reg[FRAME_START_BIT];
    endproperty
    a_hold_frame: assert property (p_hold_frame)
        else $error("frame start flag dropped without a software clear");

    property p_hold_suspend;
        @(posedge clk) disable iff (!resetn)
        flags_reg[SUSPEND_BIT] && !(wr_flags && !sfr_wdata[SUSPEND_BIT])
            |=> flags_reg[SUSPEND_BIT];
    endproperty
    a_hold_suspend: assert property (p_hold_suspend)
        else $error("suspend flag dropped without a software clear");

    property p_reserved_zero;
        @(posedge clk) disable iff (!resetn)
        ((flags_reg | enables_reg) & ~EVENT_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved flag or enable bit held a one");

    property p_addr_write;
        @(posedge clk) disable iff (!resetn)
        wr_address && !bus_reset_end
            |=> {addr_filter_on, device_address_field} == $past(sfr_wdata);
    endproperty
    a_addr_write: assert property (p_addr_write)
        else $error("address register write did not take effect");

    property p_wake_leave;
        @(posedge clk) disable iff (!resetn)
        suspended_reg && line_active && !suspend_detect |=> !suspended;
    endproperty
    a_wake_leave: assert property (p_wake_leave)
        else $error("bus activity did not end the suspended state");

endmodule // usb_global_event_and_address
`default_nettype wire

// ==== src/usb_event_pkg.sv ====
// Shared constants for the USB global event and address logic.
// Assumes an 8-bit special function register port and a 100 MHz clock.
package usb_event_pkg;

    // Register addresses on the special function register port
    localparam logic [7:0] EVENT_FLAGS_ADDR   = 8'hbd;
    localparam logic [7:0] EVENT_ENABLES_ADDR = 8'hbe;
    localparam logic [7:0] DEVICE_ADDR_ADDR   = 8'hc6;
    localparam logic [7:0] EP_SELECT_ADDR     = 8'hc7;

    // Bit positions shared by the flag and enable registers
    localparam int BUS_WAKE_BIT    = 5;
    localparam int RESET_END_BIT   = 4;
    localparam int FRAME_START_BIT = 3;
    localparam int SUSPEND_BIT     = 0;
    localparam logic [7:0] EVENT_MASK = 8'h39;

    // Address and endpoint select register layout
    localparam int FILTER_ON_BIT = 7;
    localparam logic [3:0] EP_SELECT_MASK = 4'hf;

    // Values after reset
    localparam logic [7:0] EVENT_FLAGS_RESET   = 8'h00;
    localparam logic [7:0] EVENT_ENABLES_RESET = 8'h10;
    localparam logic [7:0] DEVICE_ADDR_RESET   = 8'h80;
    localparam logic [3:0] EP_SELECT_RESET     = 4'h0;
    localparam logic [6:0] DEFAULT_ADDRESS     = 7'h00;

    // Timing: three idle frame periods before suspend
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SUSPEND_IDLE_US = 3000;
    localparam int SUSPEND_CYCLES  = SUSPEND_IDLE_US * 1000 / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W      = 20;

endpackage

// ==== src/idle_suspend_timer.sv ====
// Counts clock cycles of continuous idle J state on the bus.
// Assumes the line state input is synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module idle_suspend_timer
    import usb_event_pkg::*;
#(
    parameter int IDLE_CYCLES = SUSPEND_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Line state
    input  wire logic line_j_idle,
    // One pulse when the idle time is reached
    output logic      suspend_detect
);

    logic [IDLE_CNT_W-1:0] count_reg;
    logic                  fired_reg;
    logic                  reached;

    assign reached = (count_reg == IDLE_CNT_W'(IDLE_CYCLES - 1));

    // Fires once per idle stretch; any activity restarts the count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg      <= '0;
            fired_reg      <= 1'b0;
            suspend_detect <= 1'b0;
        end else if (!line_j_idle) begin
            count_reg      <= '0;
            fired_reg      <= 1'b0;
            suspend_detect <= 1'b0;
        end else begin
            if (!reached) begin
                count_reg <= count_reg + 1'b1;
            end
            suspend_detect <= reached && !fired_reg;
            fired_reg      <= fired_reg | reached;
        end
    end

endmodule // idle_suspend_timer
`default_nettype wire

// ==== src/token_address_filter.sv ====
// Decides whether a received token is addressed to this device.
// Assumes token_valid is a one-cycle pulse with token_addr valid alongside.
`timescale 1ns/10ps
`default_nettype none
module token_address_filter (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Stored address and filter control
    input  wire logic       filter_on,
    input  wire logic [6:0] own_address,
    // Incoming token
    input  wire logic       token_valid,
    input  wire logic [6:0] token_addr,
    // Verdict, one cycle after the token
    output logic            token_accept
);

    logic match;

    assign match = !filter_on || (token_addr == own_address);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            token_accept <= 1'b0;
        end else begin
            token_accept <= token_valid && match;
        end
    end

    property p_filter_drop;
        @(posedge clk) disable iff (!resetn)
        token_valid && filter_on && (token_addr != own_address) |=> !token_accept;
    endproperty
    a_filter_drop: assert property (p_filter_drop)
        else $error("token for another address was accepted");

    property p_filter_off;
        @(posedge clk) disable iff (!resetn)
        token_valid && !filter_on |=> token_accept;
    endproperty
    a_filter_off: assert property (p_filter_off)
        else $error("token dropped with filtering off");

endmodule // token_address_filter
`default_nettype wire

// ==== bench/usb_host_model.sv ====
// Behavioural model of the host and serial engine side of the USB event block.
// Assumes the bench calls its tasks one at a time; all outputs move at falling edges.
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
    // Clock
    input  wire logic       clk,
    // Bus events towards the device
    output logic            bus_reset_end,
    output logic            sof_pid_seen,
    output logic            line_j_idle,
    output logic            line_active,
    // Tokens towards the device
    output logic            token_valid,
    output logic      [6:0] token_addr
);
    // The bus carries traffic by default, so the idle timer stays quiet
    initial begin
        bus_reset_end = 1'b0;
        sof_pid_seen  = 1'b0;
        line_j_idle   = 1'b0;
        line_active   = 1'b1;
        token_valid   = 1'b0;
        token_addr    = 7'h55;
    end

    task automatic pulse_sof();
        @(negedge clk) sof_pid_seen = 1'b1;
        @(negedge clk) sof_pid_seen = 1'b0;
    endtask

    task automatic pulse_reset_end();
        @(negedge clk) bus_reset_end = 1'b1;
        @(negedge clk) bus_reset_end = 1'b0;
    endtask

    // Line stays idle after return, as a quiet host would leave it
    task automatic go_idle(input int n);
        @(negedge clk);
        line_active = 1'b0;
        line_j_idle = 1'b1;
        repeat (n) @(negedge clk);
    endtask

    task automatic wake();
        @(negedge clk);
        line_j_idle = 1'b0;
        line_active = 1'b1;
    endtask

    // Address is scrambled once the token is gone, so stale values cannot match
    task automatic send_token(input logic [6:0] a);
        @(negedge clk);
        token_valid = 1'b1;
        token_addr  = a;
        @(negedge clk);
        token_valid = 1'b0;
        token_addr  = ~a;
    endtask
endmodule // usb_host_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the USB global event and address block.
// Assumes the host model drives bus events; the bench plays the CPU side.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import usb_event_pkg::*;
    localparam int IDLE = 16;
    logic clk, resetn, sfr_wr, sfr_rd, upstream_resume, token_valid, token_accept;
    logic bus_reset_end, sof_pid_seen, line_j_idle, line_active;
    logic usb_irq, suspended, addr_filter_on;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [6:0] token_addr, device_address_field, a;
    logic [3:0] endpoint_select;
    logic [15:0] seed;
    logic [7:0] e, f;
    int miscompares, check_count;

    usb_global_event_and_address #(.IDLE_CYCLES(IDLE)) dut_u (
        .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bus_reset_end(bus_reset_end),
        .sof_pid_seen(sof_pid_seen), .line_j_idle(line_j_idle), .line_active(line_active),
        .upstream_resume(upstream_resume), .token_valid(token_valid),
        .token_addr(token_addr), .token_accept(token_accept), .usb_irq(usb_irq),
        .suspended(suspended), .addr_filter_on(addr_filter_on),
        .device_address_field(device_address_field), .endpoint_select(endpoint_select));

    usb_host_model host_u (
        .clk(clk), .bus_reset_end(bus_reset_end), .sof_pid_seen(sof_pid_seen),
        .line_j_idle(line_j_idle), .line_active(line_active),
        .token_valid(token_valid), .token_addr(token_addr));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic exp_irq(input logic [7:0] fl, input logic [7:0] en);
        return |(fl & en & EVENT_MASK);
    endfunction

    task automatic stop_test();
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(negedge clk);
        sfr_addr  = ad;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk) sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = ad;
        sfr_rd   = 1'b1;
        @(negedge clk) sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Generous bound: the sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    initial begin
        {resetn, sfr_wr, sfr_rd, upstream_resume} = 4'h0;
        sfr_addr  = 8'h00;
        sfr_wdata = 8'h00;
        seed      = 16'h605c;
        miscompares = 0;
        check_count = 0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        rd(EVENT_FLAGS_ADDR, 8'h00);
        rd(EVENT_ENABLES_ADDR, 8'h10);
        rd(DEVICE_ADDR_ADDR, 8'h80);
        rd(8'h10, 8'h00);
        wr(EVENT_ENABLES_ADDR, EVENT_MASK);
        rd(EVENT_ENABLES_ADDR, 8'h39);
        wr(EVENT_ENABLES_ADDR, 8'h00);
        host_u.pulse_sof();
        chk({7'h00, usb_irq}, 8'h00);
        rd(EVENT_FLAGS_ADDR, 8'h08);
        wr(EVENT_ENABLES_ADDR, 8'h08);
        @(negedge clk);
        chk({7'h00, usb_irq}, 8'h01);
        wr(EVENT_FLAGS_ADDR, 8'h00);
        @(negedge clk);
        chk({7'h00, usb_irq}, 8'h00);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = seed[6:0];
            wr(DEVICE_ADDR_ADDR, {1'b1, a});
            rd(DEVICE_ADDR_ADDR, {1'b1, a});
            chk({addr_filter_on, device_address_field}, {1'b1, a});
            host_u.send_token(a);
            chk({7'h00, token_accept}, 8'h01);
            host_u.send_token(a ^ 7'h01);
            chk({7'h00, token_accept}, 8'h00);
            wr(DEVICE_ADDR_ADDR, {1'b0, a});
            chk({addr_filter_on, device_address_field}, {1'b0, a});
            host_u.send_token(a ^ 7'h01);
            chk({7'h00, token_accept}, 8'h01);
            wr(EP_SELECT_ADDR, {4'h0, seed[11:8]});
            chk({4'h0, endpoint_select}, {4'h0, seed[11:8]});
            rd(EP_SELECT_ADDR, {4'h0, seed[11:8]});
        end
        wr(DEVICE_ADDR_ADDR, 8'hab);
        host_u.pulse_reset_end();
        rd(EVENT_FLAGS_ADDR, 8'h10);
        rd(DEVICE_ADDR_ADDR, 8'h80);
        chk({addr_filter_on, device_address_field}, 8'h80);
        wr(EVENT_FLAGS_ADDR, 8'h00);
        wr(EVENT_ENABLES_ADDR, 8'h01);
        host_u.go_idle(IDLE + 4);
        chk({6'h00, suspended, usb_irq}, 8'h03);
        rd(EVENT_FLAGS_ADDR, 8'h01);
        wr(EVENT_FLAGS_ADDR, 8'h00);
        upstream_resume = 1'b1;
        host_u.wake();
        repeat (3) @(negedge clk);
        upstream_resume = 1'b0;
        rd(EVENT_FLAGS_ADDR, 8'h00);
        wr(EVENT_ENABLES_ADDR, 8'h21);
        host_u.go_idle(IDLE + 4);
        wr(EVENT_FLAGS_ADDR, 8'h00);
        host_u.wake();
        rd(EVENT_FLAGS_ADDR, 8'h20);
        chk({7'h00, suspended}, 8'h00);
        chk({7'h00, usb_irq}, 8'h01);
        wr(EVENT_FLAGS_ADDR, 8'h00);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            e = seed[7:0] & EVENT_MASK;
            f = {3'b000, seed[9], seed[8], 3'b000};
            wr(EVENT_ENABLES_ADDR, e);
            if (seed[8])
                host_u.pulse_sof();
            if (seed[9])
                host_u.pulse_reset_end();
            @(negedge clk);
            chk({7'h00, usb_irq}, {7'h00, exp_irq(f, e)});
            rd(EVENT_FLAGS_ADDR, f);
            wr(EVENT_FLAGS_ADDR, f & 8'h10);
            rd(EVENT_FLAGS_ADDR, f & 8'h10);
            wr(EVENT_FLAGS_ADDR, 8'h00);
        end
        // Reset again mid-run: values after reset must return
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        rd(EVENT_ENABLES_ADDR, 8'h10);
        rd(DEVICE_ADDR_ADDR, 8'h80);
        chk({4'h0, endpoint_select}, 8'h00);
        stop_test();
    end
endmodule // tb
`default_nettype wire
